//--- inc/t4u_consts.vh
`ifndef T4U_CONSTS_VH
`define T4U_CONSTS_VH

// Register byte offsets
`define T4U_OFS_CTRL 8'h00
`define T4U_OFS_CMP 8'h04
`define T4U_OFS_EICR 8'h08
`define T4U_OFS_STAT 8'h0C
`define T4U_OFS_IRQ_ST 8'h10
`define T4U_OFS_IRQ_MSK 8'h14
`define T4U_OFS_CFG 8'h18

// Control register fields
`define T4U_CTRL_MODE_LO 0
`define T4U_CTRL_MODE_HI 1
`define T4U_CTRL_FFINIT 2
`define T4U_CTRL_GRPB 3
`define T4U_CTRL_RUN 4
`define T4U_CTRL_CK_LO 5
`define T4U_CTRL_CK_HI 6
`define T4U_CTRL_WMASK 8'h7F
`define T4U_CTRL_RST 8'h00

// Other fields
`define T4U_EICR_EDGE 4
`define T4U_CFG_DVSEL 0
`define T4U_STAT_FF 8
`define T4U_IRQ_MATCH 0

// Operating modes
`define T4U_MODE_TIMER 2'h0
`define T4U_MODE_EVENT 2'h1
`define T4U_MODE_PDO 2'h2
`define T4U_MODE_PWM 2'h3

// Prescaler taps (powers of two of the high-frequency clock) and last low-frequency prescaler count
`define T4U_DIV_A0 4'hB
`define T4U_DIV_A1 4'h7
`define T4U_DIV_A2 4'h3
`define T4U_DIV_B0 4'h5
`define T4U_DIV_B1 4'h2
`define T4U_DIV_B2 4'h1
`define T4U_LF_LAST 3'h7

// AXI responses
`define T4U_RESP_OKAY 2'h0
`define T4U_RESP_SLVERR 2'h2

`endif

//--- rtl/t4u_timer.v
`timescale 1ns/1ns
`include "t4u_consts.vh"

// Overview of operation
// - Interval mode counts internal ticks; match raises interrupt and restarts at zero.
// - Event mode counts external pin edges; edge chosen by bit 4 of irq control.
// - Event mode match raises interrupt and clears the counter like interval mode.
// - Divider mode toggles flip-flop and clears counter on every match.
// - Divider mode drives inverted flip-flop state onto the shared output pin.
// - Divider mode raises the interrupt on every output toggle.
// - Flip-flop is loadable from the control register; reset forces it low.
// - PWM mode is 8-bit; match toggles flip-flop, counter keeps running.
// - PWM overflow toggles again, clears counter, raises interrupt; match does not.
// - PWM mode drives inverted flip-flop state onto the same shared pin.
// - PWM compare is double buffered; new value applies after current cycle.
// - Setting the run bit copies the loaded compare value to the active stage.
// - Reset leaves the compare register contents unchanged.
// - Group A gives fc/2^11, 2^7, 2^3 outside slow modes; first becomes fs/2^3 when selected or slow.
// - Group B gives fc/32, /4, /2, /1, only outside slow modes.
module t4u_timer #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  output wire [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  // System clocking state
  input wire lf_tick,
  input wire slow_mode,
  // Far side pins
  input wire event_in,
  output wire shared_timer_out_o,
  output wire shared_timer_out_oe,
  // Interrupt
  output wire irq
);

  // True when the low n bits of the prescaler are all ones
  function pre_tick;
    input [10:0] c;
    input [3:0] n;
    reg [10:0] m;
    begin
      m = (11'h001 << n) - 11'h001;
      pre_tick = ((c & m) == m);
    end
  endfunction

  // Aligned, mapped register address check
  function addr_ok;
    input [ADDR_W-1:0] a;
    begin
      addr_ok = (a[1:0] == 2'h0) && (a <= `T4U_OFS_CFG);
    end
  endfunction

  // Bus state
  reg aw_hold_q;
  reg [ADDR_W-1:0] awaddr_q;
  reg w_hold_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;

  // Software registers
  reg [7:0] ctrl_q;
  reg [7:0] cmp_q;
  reg eicr_edge_q;
  reg dv_sel_q;
  reg irq_st_q;
  reg irq_msk_q;

  // Timer core
  reg [10:0] pre_q;
  reg [2:0] lf_q;
  reg ev_prev_q;
  reg [7:0] cnt_q;
  reg [7:0] cmp_act_q;
  reg ff_q;
  reg pin_q;

  wire [1:0] mode = ctrl_q[`T4U_CTRL_MODE_HI:`T4U_CTRL_MODE_LO];
  wire run = ctrl_q[`T4U_CTRL_RUN];
  wire [1:0] ck_sel = ctrl_q[`T4U_CTRL_CK_HI:`T4U_CTRL_CK_LO];
  wire out_mode = (mode == `T4U_MODE_PDO) || (mode == `T4U_MODE_PWM);

  // Handshakes; one write and one read in flight at most
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  wire wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  wire wr_ok = wr_fire && addr_ok(awaddr_q) && wstrb_q[0];
  wire wr_ctrl = wr_ok && (awaddr_q == `T4U_OFS_CTRL);
  wire wr_cmp = wr_ok && (awaddr_q == `T4U_OFS_CMP);
  wire wr_eicr = wr_ok && (awaddr_q == `T4U_OFS_EICR);
  wire wr_ist = wr_ok && (awaddr_q == `T4U_OFS_IRQ_ST);
  wire wr_msk = wr_ok && (awaddr_q == `T4U_OFS_IRQ_MSK);
  wire wr_cfg = wr_ok && (awaddr_q == `T4U_OFS_CFG);
  wire [7:0] ctrl_new = wdata_q[7:0] & `T4U_CTRL_WMASK;
  wire run_new = ctrl_new[`T4U_CTRL_RUN];

  // Write channel: address and data may arrive in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      awaddr_q <= {ADDR_W{1'b0}};
      w_hold_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `T4U_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= addr_ok(awaddr_q) ? `T4U_RESP_OKAY : `T4U_RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // Read channel; unmapped addresses answer SLVERR with zero data
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `T4U_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= addr_ok(s_axi_araddr) ? `T4U_RESP_OKAY
                                       : `T4U_RESP_SLVERR;
      case (s_axi_araddr)
        `T4U_OFS_CTRL: rdata_q <= {24'h000000, ctrl_q};
        `T4U_OFS_CMP: rdata_q <= {24'h000000, cmp_q};
        `T4U_OFS_EICR:
          rdata_q <= {27'h0000000, eicr_edge_q, 4'h0};
        `T4U_OFS_STAT: rdata_q <= {23'h000000, ff_q, cnt_q};
        `T4U_OFS_IRQ_ST: rdata_q <= {31'h00000000, irq_st_q};
        `T4U_OFS_IRQ_MSK: rdata_q <= {31'h00000000, irq_msk_q};
        `T4U_OFS_CFG: rdata_q <= {31'h00000000, dv_sel_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // Plain configuration registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= `T4U_CTRL_RST;
      eicr_edge_q <= 1'b0;
      dv_sel_q <= 1'b0;
      irq_msk_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= ctrl_new;
      if (wr_eicr)
        eicr_edge_q <= wdata_q[`T4U_EICR_EDGE];
      if (wr_cfg)
        dv_sel_q <= wdata_q[`T4U_CFG_DVSEL];
      if (wr_msk)
        irq_msk_q <= wdata_q[`T4U_IRQ_MATCH];
    end
  end

  // Compare value has no reset so software setup survives it
  always @(posedge aclk)
  begin
    if (wr_cmp)
      cmp_q <= wdata_q[7:0];
  end

  // Free running prescalers for both system clocks
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pre_q <= 11'h000;
      lf_q <= 3'h0;
    end
    else
    begin
      pre_q <= pre_q + 11'h001;
      if (lf_tick)
        lf_q <= lf_q + 3'h1;
    end
  end

  wire lf_div8 = lf_tick && (lf_q == `T4U_LF_LAST);
  reg src_tick;

  // Source clock choice; fc taps vanish in slow modes
  always @*
  begin
    src_tick = 1'b0;
    if (!ctrl_q[`T4U_CTRL_GRPB])
    begin
      case (ck_sel)
        2'h0: src_tick = (dv_sel_q || slow_mode) ? lf_div8
                         : pre_tick(pre_q, `T4U_DIV_A0);
        2'h1: src_tick = !slow_mode && pre_tick(pre_q, `T4U_DIV_A1);
        2'h2: src_tick = !slow_mode && pre_tick(pre_q, `T4U_DIV_A2);
        default: src_tick = 1'b0;
      endcase
    end
    else if (!slow_mode)
    begin
      case (ck_sel)
        2'h0: src_tick = pre_tick(pre_q, `T4U_DIV_B0);
        2'h1: src_tick = pre_tick(pre_q, `T4U_DIV_B1);
        2'h2: src_tick = pre_tick(pre_q, `T4U_DIV_B2);
        default: src_tick = 1'b1;
      endcase
    end
  end

  // Edge detect on the event pin; the source keeps levels long enough
  always @(posedge aclk)
  begin
    if (!aresetn)
      ev_prev_q <= 1'b0;
    else
      ev_prev_q <= event_in;
  end

  wire ev_rise = event_in && !ev_prev_q;
  wire ev_fall = !event_in && ev_prev_q;
  wire ev_edge = eicr_edge_q ? ev_fall : ev_rise;

  // Count enable by mode
  wire tick = run && ((mode == `T4U_MODE_EVENT) ? ev_edge
                                                : src_tick);
  wire [7:0] cnt_inc = cnt_q + 8'h01;
  wire hit = (cnt_inc == cmp_q);
  wire pwm_hit = (cnt_inc == cmp_act_q);
  wire pwm_ovf = (cnt_q == 8'hFF);
  reg [7:0] cnt_d;
  reg ff_d;
  reg [7:0] cmp_act_d;
  reg evt;

  // Counter, toggle flip-flop and event per mode
  always @*
  begin
    cnt_d = cnt_q;
    ff_d = ff_q;
    cmp_act_d = cmp_act_q;
    evt = 1'b0;
    if (tick)
    begin
      case (mode)
        `T4U_MODE_TIMER, `T4U_MODE_EVENT:
        begin
          cnt_d = hit ? 8'h00 : cnt_inc;
          evt = hit;
        end
        `T4U_MODE_PDO:
        begin
          cnt_d = hit ? 8'h00 : cnt_inc;
          ff_d = ff_q ^ hit;
          evt = hit;
        end
        `T4U_MODE_PWM:
        begin
          // Match and overflow at once cancel, giving a flat output
          cnt_d = cnt_inc;
          ff_d = ff_q ^ pwm_hit ^ pwm_ovf;
          evt = pwm_ovf;
          if (pwm_ovf)
            cmp_act_d = cmp_q;
        end
        default:
        begin
          cnt_d = cnt_q;
        end
      endcase
    end
    // Control write: start loads the active stage, stop zeroes and loads
    if (wr_ctrl)
    begin
      if (run_new && !run)
        cmp_act_d = cmp_q;
      if (!run_new)
      begin
        cnt_d = 8'h00;
        ff_d = ctrl_new[`T4U_CTRL_FFINIT];
      end
    end
  end

  // Core state registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= 8'h00;
      ff_q <= 1'b0;
      cmp_act_q <= 8'h00;
      pin_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_d;
      ff_q <= ff_d;
      cmp_act_q <= cmp_act_d;
      pin_q <= ~ff_d;
    end
  end

  // Sticky status; a new event beats a same-cycle clear
  always @(posedge aclk)
  begin
    if (!aresetn)
      irq_st_q <= 1'b0;
    else if (evt)
      irq_st_q <= 1'b1;
    else if (wr_ist && wdata_q[`T4U_IRQ_MATCH])
      irq_st_q <= 1'b0;
  end

  assign irq = irq_st_q && irq_msk_q;
  assign shared_timer_out_o = pin_q;
  assign shared_timer_out_oe = out_mode;

  // Protection bits are accepted and ignored; all registers are plain data
  wire unused_ok = ^{s_axi_awprot, s_axi_arprot, wstrb_q[3:1],
                     wdata_q[31:8]};

endmodule // t4u_timer

//--- sim/t4u_far_side.sv
`timescale 1ns/1ns
module t4u_far_side (
  // Clock
  input wire aclk,
  // Event source
  output logic event_in,
  // Pin load
  input wire shared_timer_out_o,
  input wire shared_timer_out_oe,
  output wire pin
);
  // Pull-up holds the pin high when undriven
  assign pin = shared_timer_out_oe ? shared_timer_out_o : 1'b1;
  initial event_in = 1'b0;
  // Eight cycles a level keeps pulses at fc/16
  task drive(input logic v);
    event_in <= v;
    repeat (8) @(posedge aclk);
  endtask
endmodule // t4u_far_side

//--- sim/t4u_timer_properties.sv
`timescale 1ns/1ns
module t4u_timer_properties (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  // Pin and interrupt
  input wire shared_timer_out_o,
  input wire shared_timer_out_oe,
  input wire irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Reset parks the pin high and undriven
  AST_RST_IDLE: assert property (disable iff (1'b0)
    !aresetn |=> shared_timer_out_o && !shared_timer_out_oe && !irq)
    else $error("outputs not idle after reset");
  AST_B_TIME: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer lost");
  AST_R_NEXT: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("write taken while answering");
  // Mode, hence pin drive, moves only on a register write
  AST_OE_WRITE: assert property (
    $changed(shared_timer_out_oe) |-> $rose(s_axi_bvalid))
    else $error("pin enable changed without write");
  AST_OUT_IDLE: assert property (
    !shared_timer_out_oe && $changed(shared_timer_out_o) |->
    $rose(s_axi_bvalid)) else $error("flip-flop moved while idle");
  COV_IRQ: cover property ($rose(irq));
  COV_PIN: cover property (shared_timer_out_oe &&
    $changed(shared_timer_out_o));
  COV_ERR: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // t4u_timer_properties

bind t4u_timer t4u_timer_properties i_props (.*);

//--- sim/t4u_timer_test.sv
`timescale 1ns/1ns
module t4u_timer_test;
  // Bench-driven inputs
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, lf_tick, slow_mode, pa, pw, pb;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rv;
  logic [1:0] rs;
  wire [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  wire [3:0] s_axi_wstrb = 4'hF;
  // Design outputs
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, event_in, shared_timer_out_o, shared_timer_out_oe;
  wire irq, pin;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer failures = 0, checks = 0, cyc = 0, n, a, i, e;
  logic [7:0] ckt [9] = '{8'h68, 8'h48, 8'h28, 8'h08, 8'h40, 8'h20,
    8'h00, 8'h00, 8'h00};
  integer hp [9] = '{4, 8, 16, 128, 32, 512, 8192, 512, 512};

  t4u_timer i_dut (.*);
  t4u_far_side i_far (.*);

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Low-frequency tick every 16 cycles; cycle count cuts a hang
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    lf_tick <= (cyc[3:0] == 4'hF);
    if (cyc == 60000)
    begin
      failures = failures + 1;
      final_report;
    end
  end

  task chk(input [31:0] s, input [31:0] e);
    checks = checks + 1;
    if (s !== e)
    begin
      failures = failures + 1;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task final_report;
    if (failures == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One bus access; channels released at the edge that takes them
  task bus(input logic w, input [7:0] ad, input [31:0] d);
    integer k;
    logic ta, tw;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_araddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    pa = 1;
    pw = w;
    pb = 1;
    k = 0;
    while (pb && k < 40)
    begin
      @(negedge aclk);
      // ta, tw and k are locals: callers keep their own loop indices
      ta = pa && (w ? s_axi_awready : s_axi_arready);
      tw = pw && s_axi_wready;
      pb = !(w ? s_axi_bvalid : s_axi_rvalid);
      rs = w ? s_axi_bresp : s_axi_rresp;
      rv = s_axi_rdata;
      k = k + 1;
      @(posedge aclk);
      if (ta)
        pa = 0;
      if (tw)
        pw = 0;
      s_axi_awvalid <= w && pa;
      s_axi_arvalid <= !w && pa;
      s_axi_wvalid <= pw;
      s_axi_bready <= w && pb;
      s_axi_rready <= !w && pb;
    end
    chk(pb, 0);
  endtask

  // Cycles until the pin next changes
  task pin_edge;
    logic p;
    n = 0;
    p = pin;
    while (pin === p && n < 20000)
    begin
      @(negedge aclk);
      n = n + 1;
    end
  endtask

  task t_reset;
    bus(1, 8'h04, 32'h5A);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    bus(0, 8'h04, 0);
    chk(rv[7:0], 8'h5A);
    bus(0, 8'h00, 0);
    chk(rv, 0);
    chk(pin, 1);
    bus(0, 8'h0C, 0);
    chk(rv, 0);
    bus(1, 8'h1C, 1);
    chk(rs, 2'h2);
    bus(0, 8'h1C, 0);
    chk(rs, 2'h2);
  endtask

  // Match every three clocks, then mask, stop and clear
  task t_interval;
    bus(1, 8'h14, 1);
    bus(1, 8'h04, 3);
    bus(1, 8'h00, 32'h78);
    bus(0, 8'h0C, 0);
    chk(rv[7:0] < 8'h03, 1);
    chk(irq, 1);
    bus(1, 8'h14, 0);
    chk(irq, 0);
    bus(1, 8'h00, 32'h08);
    bus(1, 8'h10, 1);
    bus(1, 8'h14, 1);
    chk(irq, 0);
    bus(0, 8'h0C, 0);
    chk(rv[7:0], 0);
  endtask

  task t_event;
    bus(1, 8'h04, 3);
    for (e = 0; e < 2; e++)
    begin
      bus(1, 8'h08, e << 4);
      bus(1, 8'h00, 0);
      bus(1, 8'h00, 32'h11);
      i_far.drive(1);
      bus(0, 8'h0C, 0);
      chk(rv[7:0], e ? 0 : 1);
      i_far.drive(0);
      bus(0, 8'h0C, 0);
      chk(rv[7:0], 1);
      for (i = 0; i < 4; i++)
        i_far.drive(~i[0]);
      bus(0, 8'h0C, 0);
      chk(rv[7:0], 0);
      chk(irq, 1);
      bus(1, 8'h10, 1);
    end
  endtask

  // Divider half period is the compare value in source ticks
  task t_pdo;
    bus(1, 8'h04, 4);
    bus(1, 8'h00, 32'h06);
    chk(pin, 0);
    for (i = 0; i < 9; i++)
    begin
      bus(1, 8'h18, i == 7);
      slow_mode <= (i == 8);
      bus(1, 8'h00, 0);
      bus(1, 8'h00, ckt[i] | 8'h12);
      pin_edge;
      pin_edge;
      chk(n, hp[i]);
      pin_edge;
      chk(n, hp[i]);
    end
    chk(irq, 1);
    bus(1, 8'h00, 0);
    slow_mode <= 1'b0;
    bus(1, 8'h10, 1);
  endtask

  task t_pwm(input [7:0] c, input integer lo);
    bus(1, 8'h00, 0);
    bus(1, 8'h04, c);
    bus(1, 8'h10, 1);
    bus(1, 8'h00, 32'h7B);
    pin_edge;
    chk(irq, 0);
    pin_edge;
    a = n;
    pin_edge;
    chk(a + n, 256);
    chk(a == lo || a == 256 - lo, 1);
    chk(irq, 1);
  endtask

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
      s_axi_rready, slow_mode} = 7'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_interval;
    t_event;
    t_pdo;
    t_pwm(8'h40, 64);
    // Written just after a match: no early toggle, new duty after overflow
    bus(1, 8'h04, 32'h80);
    pin_edge;
    chk(n > 128, 1);
    pin_edge;
    chk(n, 128);
    pin_edge;
    chk(n, 128);
    t_pwm(8'h20, 32);
    final_report;
  end
endmodule // t4u_timer_test
